//--- pkg/lsc_consts.svh
// Purpose: constants for the limit switch stop control block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes:   register index 0x01 maps to byte address 0x04
// What this block does
// [RQ1] left input stops motion only when bit 0 set; bit 2 polarity
// [RQ2] right input stops motion only when bit 1 set; bit 3 polarity
// [RQ3] bit 4 swaps which direction each switch blocks
// [RQ4] bit 5 clear: switch stop zeroes velocity at once
// [RQ5] bit 5 set: switch stop ramps velocity linearly down
// [RQ6] bit 6 enables virtual left position bound
// [RQ7] bit 7 enables virtual right position bound
// [RQ8] mode 1 virtual stop zeroes velocity; 0,3 reserved
// [RQ9] mode 2 virtual stop ramps velocity linearly down
// [RQ10] bit 10 latches position when left goes inactive
// [RQ11] bit 11 latches position when left goes active
// [RQ12] synchronise inputs, apply polarity; stop only toward block
`ifndef LSC_CONSTS_SVH
`define LSC_CONSTS_SVH
`define LSC_IDX_CONFIG       8'h01
`define LSC_IDX_VIRT_LEFT    8'h02
`define LSC_IDX_VIRT_RIGHT   8'h03
`define LSC_IDX_LATCH        8'h04
`define LSC_IDX_STATUS       8'h05
`define LSC_IDX_DECEL        8'h06
`define LSC_CONFIG_RESET     32'h00000000
`define LSC_DECEL_RESET      32'h00000001
`define LSC_BIT_LEFT_EN      0
`define LSC_BIT_RIGHT_EN     1
`define LSC_BIT_POL_LEFT     2
`define LSC_BIT_POL_RIGHT    3
`define LSC_BIT_SWAP_DIR     4
`define LSC_BIT_SOFT_STOP    5
`define LSC_BIT_VLEFT_EN     6
`define LSC_BIT_VRIGHT_EN    7
`define LSC_VMODE_LO         8
`define LSC_VMODE_HI         9
`define LSC_BIT_LATCH_INACT  10
`define LSC_BIT_LATCH_ACT    11
`define LSC_CFG_USED_BITS    32'h00000FFF
`define LSC_VMODE_HARD       2'h1
`define LSC_VMODE_SOFT       2'h2
`define LSC_RESP_OKAY        2'h0
`define LSC_RESP_SLVERR      2'h2
`endif

//--- pkg/lsc_pkg.sv
// Purpose: types for the limit switch stop control block
// Assumes: lsc_consts.svh for numeric constants
// Notes:   none
package lsc_pkg;
    typedef enum logic [1:0] {
        LSC_RUN,
        LSC_HARD,
        LSC_SOFT
    } lsc_stop_e;
    typedef struct packed {
        logic left_active;
        logic right_active;
        logic block_neg;
        logic block_pos;
    } lsc_sw_s;
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic [1:0]  resp;
    } lsc_rd_s;
endpackage

//--- rtl/lsc_limit_stop.sv
// Purpose: limit switch and virtual limit stop control with position latch
// Assumes: single 125 MHz clock, synchronous active-low reset
// Notes:   velocity is signed; positive means positive direction
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "lsc_consts.svh"
module lsc_limit_stop
    import lsc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        left_limit_input,
    input  wire logic        right_limit_input,
    input  wire logic [31:0] actual_position,
    input  wire logic [31:0] request_velocity,
    output logic [31:0]      actual_velocity,
    output logic             stop_active,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] reference_switch_config;
    logic [31:0] virt_left_bound;
    logic [31:0] virt_right_bound;
    logic [31:0] latched_position;
    logic [31:0] decel_step;
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic [1:0]  next_bresp;
    lsc_rd_s     rd;
    lsc_sw_s     sw;
    lsc_stop_e   stop_state;
    logic [2:0]  left_sync;
    logic [2:0]  right_sync;
    logic        left_level;
    logic        right_level;
    logic        left_act_q;
    logic        left_act_seen;
    logic        hit_left;
    logic        hit_right;
    logic        moving_pos;
    logic        moving_neg;
    logic        ext_stop;
    logic        virt_stop;
    logic [1:0]  vmode;
    logic        do_write;
    logic [5:0]  wr_idx;

    ////////////////////////////////////////////////////////////////////////
    // write path: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign wr_idx        = aw_addr[7:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 32'h00000000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        if (wr_idx == 6'(`LSC_IDX_CONFIG)) begin
            next_bresp = `LSC_RESP_OKAY;
        end else if (wr_idx == 6'(`LSC_IDX_VIRT_LEFT)) begin
            next_bresp = `LSC_RESP_OKAY;
        end else if (wr_idx == 6'(`LSC_IDX_VIRT_RIGHT)) begin
            next_bresp = `LSC_RESP_OKAY;
        end else if (wr_idx == 6'(`LSC_IDX_DECEL)) begin
            next_bresp = `LSC_RESP_OKAY;
        end else begin
            next_bresp = `LSC_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reference_switch_config <= `LSC_CONFIG_RESET;
            virt_left_bound         <= 32'h00000000;
            virt_right_bound        <= 32'h00000000;
            decel_step              <= `LSC_DECEL_RESET;
        end else if (do_write && aw_addr[31:8] == 24'h000000) begin
            if (wr_idx == 6'(`LSC_IDX_CONFIG)) begin
                // upper bits belong to functions not built here
                reference_switch_config <= merge(reference_switch_config, w_data, w_strb)
                                           & `LSC_CFG_USED_BITS;
            end else if (wr_idx == 6'(`LSC_IDX_VIRT_LEFT)) begin
                virt_left_bound <= merge(virt_left_bound, w_data, w_strb);
            end else if (wr_idx == 6'(`LSC_IDX_VIRT_RIGHT)) begin
                virt_right_bound <= merge(virt_right_bound, w_data, w_strb);
            end else if (wr_idx == 6'(`LSC_IDX_DECEL)) begin
                decel_step <= merge(decel_step, w_data, w_strb);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `LSC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[31:8] == 24'h000000) ? next_bresp : `LSC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path: one read at a time, answer the cycle after the address
    assign s_axi_arready = !rd.valid;
    assign s_axi_rvalid  = rd.valid;
    assign s_axi_rdata   = rd.data;
    assign s_axi_rresp   = rd.resp;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd.valid <= 1'b1;
            rd.resp  <= `LSC_RESP_OKAY;
            if (s_axi_araddr[31:8] != 24'h000000) begin
                rd.data <= 32'h00000000;
                rd.resp <= `LSC_RESP_SLVERR;
            end else if (s_axi_araddr[7:2] == 6'(`LSC_IDX_CONFIG)) begin
                rd.data <= reference_switch_config;
            end else if (s_axi_araddr[7:2] == 6'(`LSC_IDX_VIRT_LEFT)) begin
                rd.data <= virt_left_bound;
            end else if (s_axi_araddr[7:2] == 6'(`LSC_IDX_VIRT_RIGHT)) begin
                rd.data <= virt_right_bound;
            end else if (s_axi_araddr[7:2] == 6'(`LSC_IDX_LATCH)) begin
                rd.data <= latched_position;
            end else if (s_axi_araddr[7:2] == 6'(`LSC_IDX_STATUS)) begin
                rd.data <= {26'h0000000, stop_state, sw};
            end else if (s_axi_araddr[7:2] == 6'(`LSC_IDX_DECEL)) begin
                rd.data <= decel_step;
            end else begin
                rd.data <= 32'h00000000;
                rd.resp <= `LSC_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rd.valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // switch inputs: three stages, a change counts once stages 2 and 3 agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_sync  <= 3'h0;
            right_sync <= 3'h0;
            left_level <= 1'b0;
            right_level <= 1'b0;
        end else begin
            left_sync  <= {left_sync[1:0], left_limit_input};           // RQ12
            right_sync <= {right_sync[1:0], right_limit_input};         // RQ12
            if (left_sync[2] == left_sync[1]) begin
                left_level <= left_sync[2];
            end
            if (right_sync[2] == right_sync[1]) begin
                right_level <= right_sync[2];
            end
        end
    end

    assign vmode = reference_switch_config[`LSC_VMODE_HI:`LSC_VMODE_LO];

    always_comb begin
        sw.left_active  = left_level == reference_switch_config[`LSC_BIT_POL_LEFT];   // RQ1
        sw.right_active = right_level == reference_switch_config[`LSC_BIT_POL_RIGHT]; // RQ2
        hit_left  = sw.left_active && reference_switch_config[`LSC_BIT_LEFT_EN];      // RQ1
        hit_right = sw.right_active && reference_switch_config[`LSC_BIT_RIGHT_EN];    // RQ2
        if (reference_switch_config[`LSC_BIT_SWAP_DIR]) begin                         // RQ3
            sw.block_pos = hit_left;
            sw.block_neg = hit_right;
        end else begin
            sw.block_neg = hit_left;
            sw.block_pos = hit_right;
        end
    end

    assign moving_pos = !actual_velocity[31] && actual_velocity != 32'h00000000;
    assign moving_neg = actual_velocity[31];
    // only motion toward a blocked side is stopped; backing away stays free
    assign ext_stop = (sw.block_pos && moving_pos) || (sw.block_neg && moving_neg);    // RQ12
    assign virt_stop = (reference_switch_config[`LSC_BIT_VLEFT_EN] && moving_neg       // RQ6
                        && $signed(actual_position) <= $signed(virt_left_bound))
                    || (reference_switch_config[`LSC_BIT_VRIGHT_EN] && moving_pos      // RQ7
                        && $signed(actual_position) >= $signed(virt_right_bound));

    ////////////////////////////////////////////////////////////////////////
    // stop sequencing; reserved virtual modes fall back to hard stop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stop_state <= LSC_RUN;
        end else begin
            case (stop_state)
                LSC_RUN: begin
                    if (ext_stop && !reference_switch_config[`LSC_BIT_SOFT_STOP]) begin
                        stop_state <= LSC_HARD;                                         // RQ4
                    end else if (ext_stop) begin
                        stop_state <= LSC_SOFT;                                         // RQ5
                    end else if (virt_stop && vmode == `LSC_VMODE_SOFT) begin
                        stop_state <= LSC_SOFT;                                         // RQ9
                    end else if (virt_stop) begin
                        stop_state <= LSC_HARD;                                         // RQ8
                    end
                end
                default: begin
                    if (!ext_stop && !virt_stop) begin
                        stop_state <= LSC_RUN;
                    end
                end
            endcase
        end
    end

    assign stop_active = stop_state != LSC_RUN;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            actual_velocity <= 32'h00000000;
        end else begin
            case (stop_state)
                LSC_HARD: actual_velocity <= 32'h00000000;                              // RQ4 RQ8
                LSC_SOFT: begin
                    // linear ramp: fixed step per cycle, clamped at zero
                    if (moving_pos) begin
                        actual_velocity <= (actual_velocity > decel_step)
                                         ? actual_velocity - decel_step : 32'h00000000; // RQ5 RQ9
                    end else if (moving_neg) begin
                        actual_velocity <= ((-actual_velocity) > decel_step)
                                         ? actual_velocity + decel_step : 32'h00000000; // RQ5 RQ9
                    end
                end
                default: actual_velocity <= request_velocity;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // position latch on left switch edges, after polarity
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_act_q       <= 1'b0;
            left_act_seen    <= 1'b0;
            latched_position <= 32'h00000000;
        end else begin
            left_act_q    <= sw.left_active;
            left_act_seen <= 1'b1;
            // first cycle after reset has no history, so no edge
            if (left_act_seen && !left_act_q && sw.left_active
                && reference_switch_config[`LSC_BIT_LATCH_ACT]) begin
                latched_position <= actual_position;                                   // RQ11
            end else if (left_act_seen && left_act_q && !sw.left_active
                && reference_switch_config[`LSC_BIT_LATCH_INACT]) begin
                latched_position <= actual_position;                                   // RQ10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    chk_hard_ext_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_state == LSC_HARD |=> actual_velocity == 32'h00000000)
        else $error("hard stop did not zero velocity"); // RQ4
    chk_soft_ext_path: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_state == LSC_RUN && ext_stop && reference_switch_config[`LSC_BIT_SOFT_STOP]
        |=> stop_state == LSC_SOFT)
        else $error("soft stop not entered"); // RQ5
    chk_hard_ext_path: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_state == LSC_RUN && ext_stop && !reference_switch_config[`LSC_BIT_SOFT_STOP]
        |=> stop_state == LSC_HARD)
        else $error("hard stop not entered"); // RQ4
    chk_left_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
        !reference_switch_config[`LSC_BIT_LEFT_EN] && !reference_switch_config[`LSC_BIT_SWAP_DIR]
        |-> !sw.block_neg)
        else $error("disabled left switch blocks"); // RQ1
    chk_right_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
        !reference_switch_config[`LSC_BIT_RIGHT_EN] && !reference_switch_config[`LSC_BIT_SWAP_DIR]
        |-> !sw.block_pos)
        else $error("disabled right switch blocks"); // RQ2
    chk_swap_dir: assert property (@(posedge aclk) disable iff (!aresetn)
        reference_switch_config[`LSC_BIT_SWAP_DIR] |-> sw.block_pos == hit_left
        && sw.block_neg == hit_right)
        else $error("direction swap wrong"); // RQ3
    chk_virt_left_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !reference_switch_config[`LSC_BIT_VLEFT_EN] && !reference_switch_config[`LSC_BIT_VRIGHT_EN]
        |-> !virt_stop)
        else $error("virtual stop while disabled"); // RQ6
    chk_virt_right_on: assert property (@(posedge aclk) disable iff (!aresetn)
        reference_switch_config[`LSC_BIT_VRIGHT_EN] && moving_pos && !ext_stop
        && stop_state == LSC_RUN
        && $signed(actual_position) >= $signed(virt_right_bound)
        && vmode == `LSC_VMODE_HARD |=> stop_state == LSC_HARD)
        else $error("virtual right hard stop missed"); // RQ7
    chk_virt_soft: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_state == LSC_RUN && !ext_stop && virt_stop && vmode == `LSC_VMODE_SOFT
        |=> stop_state == LSC_SOFT)
        else $error("virtual soft stop missed"); // RQ9
    chk_virt_hard: assert property (@(posedge aclk) disable iff (!aresetn)
        stop_state == LSC_RUN && !ext_stop && virt_stop && vmode == `LSC_VMODE_HARD
        |=> ##1 actual_velocity == 32'h00000000)
        else $error("virtual hard stop did not zero"); // RQ8
    chk_latch_active: assert property (@(posedge aclk) disable iff (!aresetn)
        left_act_seen && !left_act_q && sw.left_active
        && reference_switch_config[`LSC_BIT_LATCH_ACT]
        |=> latched_position == $past(actual_position))
        else $error("latch on active edge missed"); // RQ11
    chk_latch_inactive: assert property (@(posedge aclk) disable iff (!aresetn)
        left_act_seen && left_act_q && !sw.left_active
        && reference_switch_config[`LSC_BIT_LATCH_INACT]
        |=> latched_position == $past(actual_position))
        else $error("latch on inactive edge missed"); // RQ10
    chk_no_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        reference_switch_config[`LSC_BIT_LATCH_ACT:`LSC_BIT_LATCH_INACT] == 2'h0
        |=> $stable(latched_position))
        else $error("latch without enable"); // RQ10
    chk_sync_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        !$stable(left_level) |-> left_sync[2] == left_level)
        else $error("level changed without agreement"); // RQ12

endmodule // lsc_limit_stop

//--- tb/lsc_switch_model.sv
// Purpose: behavioural pair of left and right limit switches
// Assumes: contacts are bounce-free and wired with no pull resistor
// Notes:   a released switch shows the inverse of its active level
`timescale 1ns/100ps
module lsc_switch_model (
    input  wire logic left_pressed,
    input  wire logic right_pressed,
    input  wire logic left_high_active,
    input  wire logic right_high_active,
    output logic      left_limit_input,
    output logic      right_limit_input
);
    ////////////////////////////////////////////////////////////////////////////
    // pressed gives the wired active level, released gives its inverse
    assign left_limit_input  = left_pressed ^ ~left_high_active;
    assign right_limit_input = right_pressed ^ ~right_high_active;
endmodule // lsc_switch_model

//--- tb/limit_switch_stop_control_bench.sv
// Purpose: self-checking bench for the limit stop block
// Assumes: AXI4-Lite master tasks, switch pair model on the pins
// Notes:   bounds 10 and 1000, soft decel step 4
`timescale 1ns/100ps
`include "lsc_consts.svh"
module limit_switch_stop_control_bench;
    import lsc_pkg::*;
    localparam logic [31:0] A_CFG = {22'h0, `LSC_IDX_CONFIG, 2'h0};
    localparam logic [31:0] A_VL  = {22'h0, `LSC_IDX_VIRT_LEFT, 2'h0};
    localparam logic [31:0] A_VR  = {22'h0, `LSC_IDX_VIRT_RIGHT, 2'h0};
    localparam logic [31:0] A_LAT = {22'h0, `LSC_IDX_LATCH, 2'h0};
    localparam logic [31:0] A_DEC = {22'h0, `LSC_IDX_DECEL, 2'h0};
    localparam logic [31:0] NEG   = 32'hFFFFFF9C;
    logic        aclk, aresetn, lp, rp, lh, rh, l_pin, r_pin, stop_active;
    logic [31:0] actual_position, request_velocity, actual_velocity, d;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, r;
    logic [3:0]  wstrb;
    int          bad_count, n_checks;
    ////////////////////////////////////////////////////////////////////////////
    lsc_switch_model sw_u (.left_pressed(lp), .right_pressed(rp), .left_high_active(lh),
        .right_high_active(rh), .left_limit_input(l_pin), .right_limit_input(r_pin));
    lsc_limit_stop dut_u (.aclk(aclk), .aresetn(aresetn), .left_limit_input(l_pin),
        .right_limit_input(r_pin), .actual_position(actual_position),
        .request_velocity(request_velocity), .actual_velocity(actual_velocity),
        .stop_active(stop_active), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    always #4 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // ready is sampled at the negedge; inputs only move at posedges
    task automatic wr(input logic [31:0] a, input logic [31:0] dat);
        bit aw_p, w_p, b_p, aw_h, w_h, b_h;
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= dat; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        aw_p = 1; w_p = 1; b_p = 1; n = 0;
        while (b_p && n < 100) begin
            @(negedge aclk);
            aw_h = aw_p && awready; w_h = w_p && wready; b_h = bvalid; r = bresp;
            @(posedge aclk);
            if (aw_h) begin awvalid <= 1'b0; aw_p = 0; end
            if (w_h) begin wvalid <= 1'b0; w_p = 0; end
            if (b_h) begin bready <= 1'b0; b_p = 0; end
            n++;
        end
        if (b_p) chk("write timeout", 32'h1, 32'h0);
    endtask
    task automatic rd(input logic [31:0] a);
        bit a_p, r_p, a_h, r_h;
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        a_p = 1; r_p = 1; n = 0;
        while (r_p && n < 100) begin
            @(negedge aclk);
            a_h = a_p && arready; r_h = rvalid; d = rdata; r = rresp;
            @(posedge aclk);
            if (a_h) begin arvalid <= 1'b0; a_p = 0; end
            if (r_h) begin rready <= 1'b0; r_p = 0; end
            n++;
        end
        if (r_p) chk("read timeout", 32'h1, 32'h0);
    endtask
    // mode 0: velocity follows, 1: instant zero, 2: ramp to zero
    task automatic run(input string nm, input logic [31:0] cfg, input logic [31:0] v,
                       input logic [31:0] pos, input logic l, input logic rr, input int mode);
        int n;
        wr(A_CFG, cfg);
        request_velocity <= v; actual_position <= pos; lp <= l; rp <= rr;
        lh <= cfg[`LSC_BIT_POL_LEFT]; rh <= cfg[`LSC_BIT_POL_RIGHT];
        if (mode == 0) begin
            repeat (20) @(posedge aclk);
            @(negedge aclk);
            chk(nm, actual_velocity, v);
            chk(nm, {31'h0, stop_active}, 32'h0);
        end else begin
            n = 0;
            @(negedge aclk);
            while (stop_active !== 1'b1 && n < 40) begin @(negedge aclk); n++; end
            chk(nm, {31'h0, stop_active}, 32'h1);
            @(negedge aclk);
            chk(nm, {31'h0, actual_velocity !== 32'h0}, (mode == 2) ? 32'h1 : 32'h0);
            n = 0;
            while (actual_velocity !== 32'h0 && n < 60) begin @(negedge aclk); n++; end
            chk(nm, actual_velocity, 32'h0);
        end
        @(posedge aclk);
        request_velocity <= 32'h0; lp <= 1'b0; rp <= 1'b0;
        repeat (10) @(posedge aclk);
        $display("test %s done", nm);
    endtask
    task automatic latch_step(input string nm, input logic [31:0] cfg, input logic [31:0] pos,
                              input logic l, input logic [31:0] exp);
        wr(A_CFG, cfg);
        actual_position <= pos; lp <= l;
        repeat (20) @(posedge aclk);
        rd(A_LAT);
        chk(nm, d, exp);
        $display("test %s done", nm);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge aclk);
        bad_count++;
        summarize;
    end
    initial begin
        aclk = 0; aresetn = 0; lp = 0; rp = 0; lh = 0; rh = 0; bad_count = 0; n_checks = 0;
        actual_position = 32'd500; request_velocity = 0; awaddr = 0; wdata = 0; araddr = 0;
        awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; wstrb = 4'hF;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_CFG); chk("config reset", d, `LSC_CONFIG_RESET);
        wr(A_CFG, 32'hFFFFFFFF); rd(A_CFG); chk("config width", d, `LSC_CFG_USED_BITS);
        rd(32'h00000040); chk("unmapped resp", {30'h0, r}, {30'h0, `LSC_RESP_SLVERR});
        wr(A_LAT, 32'h1); chk("latch ro resp", {30'h0, r}, {30'h0, `LSC_RESP_SLVERR});
        wstrb <= 4'h1; wr(A_VL, 32'hFFFFFF0A); rd(A_VL);
        chk("strobe lanes", d, 32'h0000000A);
        wstrb <= 4'hF; wr(A_VL, 32'd10); wr(A_VR, 32'd1000); wr(A_DEC, 32'h4);
        chk("write okay", {30'h0, r}, {30'h0, `LSC_RESP_OKAY});
        $display("test registers done");
        run("left off", 32'h000, NEG, 32'd500, 1, 0, 0);
        run("left low hard", 32'h001, NEG, 32'd500, 1, 0, 1);
        run("left away", 32'h001, 32'd100, 32'd500, 1, 0, 0);
        run("left high", 32'h005, NEG, 32'd500, 1, 0, 1);
        run("left swap", 32'h011, 32'd100, 32'd500, 1, 0, 1);
        run("right off", 32'h000, 32'd100, 32'd500, 0, 1, 0);
        run("right soft", 32'h02A, 32'd100, 32'd500, 0, 1, 2);
        run("right away", 32'h00A, NEG, 32'd500, 0, 1, 0);
        run("right swap", 32'h01A, NEG, 32'd500, 0, 1, 1);
        run("vleft off", 32'h100, NEG, 32'd5, 0, 0, 0);
        run("vleft hard", 32'h140, NEG, 32'd5, 0, 0, 1);
        run("vright soft", 32'h280, 32'd100, 32'd2000, 0, 0, 2);
        run("vright off", 32'h200, 32'd100, 32'd2000, 0, 0, 0);
        run("vright hard", 32'h180, 32'd100, 32'd2000, 0, 0, 1);
        latch_step("latch on active", 32'h801, 32'h1234, 1, 32'h1234);
        latch_step("no inactive latch", 32'h801, 32'h5678, 0, 32'h1234);
        latch_step("no active latch", 32'h401, 32'h9ABC, 1, 32'h1234);
        latch_step("latch on inactive", 32'h401, 32'h9ABC, 0, 32'h9ABC);
        summarize;
    end
endmodule // limit_switch_stop_control_bench
